// File: vector_map_select_pkg.sv
package vector_map_select_pkg;
  localparam int NUM_GROUPS = 12;
  localparam int GROUP_SIZE = 8;
  localparam int NUM_VECT = 96;
  localparam int NUM_EV = 2;
  localparam int EV_FALLBACK = 0;
  localparam int EV_BLOCKED = 1;
  localparam logic [31:0] OFF_STATUS_ONE = 32'h00000000;
  localparam logic [31:0] OFF_STATUS_SETCLR = 32'h00000004;
  localparam logic [31:0] OFF_ALLOW = 32'h00000008;
  localparam logic [31:0] OFF_ACK = 32'h0000000C;
  localparam logic [31:0] OFF_IRQ_STATUS = 32'h00000010;
  localparam logic [31:0] OFF_IRQ_CLEAR = 32'h00000014;
  localparam logic [31:0] OFF_IRQ_ENABLE = 32'h00000018;
  localparam logic [31:0] OFF_ENABLE_BASE = 32'h00000040;
  localparam logic [31:0] OFF_FLAG_BASE = 32'h00000080;
  localparam logic [31:0] OFF_EXP_CTRL = 32'h00000CE0;
  localparam logic [31:0] OFF_VECT_BASE = 32'h00001000;
  localparam int BIT_MAP_SEL = 3;
  localparam int BIT_SWAP = 11;
  localparam int BIT_OBJ_COMPAT = 9;
  localparam int BIT_ADDR_COMPAT = 8;
  localparam int BIT_EXP_EN = 0;
  localparam int BIT_ALLOW = 0;
  localparam logic [15:0] STATUS_ONE_RESET = 16'h0808;
  localparam logic [21:0] BOOT_ROM_VEC_BASE = 22'h3FFFC0;
  localparam logic [21:0] EXP_VEC_BASE = 22'h000D00;
  localparam logic [21:0] RAM_VEC_BASE = 22'h000000;
  localparam logic [7:0] CORE_IDX_BASE = 8'h01;
  localparam logic [7:0] GROUP_IDX_BASE = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MAP_RAM_ONE = 2'b00, MAP_RAM_ZERO = 2'b01, MAP_BOOT_ROM = 2'b11, MAP_EXPANSION = 2'b10
  } vector_map_t;
  typedef enum logic [1:0] {
    MODE_OBJECT = 2'b00, MODE_RESERVED = 2'b01, MODE_NATIVE = 2'b10, MODE_SOURCE = 2'b11
  } compat_mode_t;
  typedef struct packed {logic valid; logic reset_vec; logic [3:0] group;} fetch_req_t;
  typedef struct packed {
    logic valid; vector_map_t map; logic [21:0] addr; logic [31:0] data; logic fallback;
  } vector_rsp_t;
  typedef struct packed {logic valid; logic [31:0] addr; logic [31:0] data; logic [3:0] strb;} reg_wr_t;
  typedef struct packed {logic valid; logic [31:0] addr;} reg_rd_t;
  typedef struct packed {
    logic have_aw; logic [31:0] aw_addr; logic have_w; logic [31:0] wdata; logic [3:0] wstrb;
    logic bvalid; logic [1:0] bresp; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } axil_state_t;
  typedef struct packed {
    logic [15:0] status_one; logic exp_en; logic allow; logic [11:0] ack;
    logic [11:0][7:0] enable; logic [11:0][7:0] flag;
    logic [1:0] irq_status; logic [1:0] irq_enable; logic [11:0] cpu_int;
    vector_rsp_t rsp; logic [95:0][31:0] vect;
  } map_state_t;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction
  function automatic logic in_window(input logic [31:0] addr, input logic [31:0] base,
                                     input int count);
    return addr[1:0] == 2'b00 && addr >= base && addr < base + 32'(count * 4);
  endfunction
  function automatic logic [6:0] word_index(input logic [31:0] addr, input logic [31:0] base);
    logic [31:0] d;
    d = addr - base;
    return d[8:2];
  endfunction
  function automatic logic [21:0] vec_addr(input logic [21:0] base, input logic [7:0] idx);
    return base + {13'h0000, idx, 1'b0};
  endfunction
endpackage

// File: group_vector_pick.sv
`timescale 1ns/1ps
module group_vector_pick (
  // candidates, bit 0 has the highest priority
  input wire logic [7:0] pending_in,
  // winner
  output logic found_out,
  output logic [2:0] index_out
);
  always_comb begin
    found_out = 1'b0;
    index_out = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (pending_in[i]) begin
        found_out = 1'b1;
        index_out = 3'(i);
      end
    end
  end
endmodule

// File: axil_reg_port.sv
`timescale 1ns/1ps
module axil_reg_port (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // axi4-lite write
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // register side
  output vector_map_select_pkg::reg_wr_t wr_out,
  input wire logic wr_err_in,
  output vector_map_select_pkg::reg_rd_t rd_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_err_in
);
  vector_map_select_pkg::axil_state_t s, next_s;

  assign s_axi_awready_out = !s.have_aw && !s.bvalid;
  assign s_axi_wready_out = !s.have_w && !s.bvalid;
  assign s_axi_arready_out = !s.rvalid;
  assign s_axi_bvalid_out = s.bvalid;
  assign s_axi_bresp_out = s.bresp;
  assign s_axi_rvalid_out = s.rvalid;
  assign s_axi_rdata_out = s.rdata;
  assign s_axi_rresp_out = s.rresp;
  assign wr_out = '{valid: s.have_aw && s.have_w, addr: s.aw_addr, data: s.wdata, strb: s.wstrb};
  assign rd_out = '{valid: s_axi_arvalid_in && !s.rvalid, addr: s_axi_araddr_in};

  always_comb begin
    next_s = s;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_s.have_aw = 1'b1;
      next_s.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_s.have_w = 1'b1;
      next_s.wdata = s_axi_wdata_in;
      next_s.wstrb = s_axi_wstrb_in;
    end
    // one write in flight: both halves held, applied once, then answered
    if (wr_out.valid) begin
      next_s.have_aw = 1'b0;
      next_s.have_w = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_err_in ? vector_map_select_pkg::RESP_SLVERR : vector_map_select_pkg::RESP_OKAY;
    end else if (s.bvalid && s_axi_bready_in) begin
      next_s.bvalid = 1'b0;
    end
    if (rd_out.valid) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_data_in;
      next_s.rresp = rd_err_in ? vector_map_select_pkg::RESP_SLVERR : vector_map_select_pkg::RESP_OKAY;
    end else if (s.rvalid && s_axi_rready_in) begin
      next_s.rvalid = 1'b0;
    end
    if (!reset_n_in) next_s = '0;
  end

  always_ff @(posedge mclk_in) begin
    s <= next_s;
  end
endmodule

// File: interrupt_vector_map_select.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module interrupt_vector_map_select (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // peripheral requests, group g interrupt y on bit 8*g+y
  input wire logic [95:0] periph_req_in,
  // cpu core
  input wire vector_map_select_pkg::fetch_req_t fetch_in,
  output vector_map_select_pkg::vector_rsp_t vector_out,
  output logic [11:0] cpu_int_out,
  output logic [11:0] group_ack_out,
  // mode status
  output vector_map_select_pkg::vector_map_t active_map_out,
  output vector_map_select_pkg::compat_mode_t compat_mode_out,
  output logic ram_block_zero_free_out,
  output logic ram_block_one_free_out,
  output logic expansion_vector_enable_out,
  // software interrupt
  output logic interrupt_out
);
  vector_map_select_pkg::map_state_t s, next_s;
  vector_map_select_pkg::reg_wr_t wr;
  vector_map_select_pkg::reg_rd_t rd;
  vector_map_select_pkg::vector_map_t cur_map;
  logic [31:0] rd_data;
  logic [31:0] tmp;
  logic rd_err;
  logic wr_err;
  logic [3:0] grp;
  logic grp_ok;
  logic [7:0] pend;
  logic found;
  logic [2:0] pick_idx;
  logic [6:0] pick_slot;
  logic [21:0] map_base;

  ////////////////////////////////////////////////////////////////////////////////
  axil_reg_port bus (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .s_axi_awaddr_in(s_axi_awaddr_in),
    .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wstrb_in(s_axi_wstrb_in),
    .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out),
    .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in),
    .wr_out(wr),
    .wr_err_in(wr_err),
    .rd_out(rd),
    .rd_data_in(rd_data),
    .rd_err_in(rd_err)
  );

  group_vector_pick pick (
    .pending_in(pend),
    .found_out(found),
    .index_out(pick_idx)
  );

  ////////////////////////////////////////////////////////////////////////////////
  assign grp = fetch_in.group;
  assign grp_ok = grp < 4'(vector_map_select_pkg::NUM_GROUPS);
  assign pend = grp_ok ? (s.flag[grp] & s.enable[grp]) : 8'h00;
  // an out-of-range group must not point outside the expansion table
  assign pick_slot = grp_ok ? {grp, 3'h0} + {4'h0, pick_idx} : 7'h00;
  assign cur_map = !s.status_one[vector_map_select_pkg::BIT_MAP_SEL]
                 ? (s.status_one[vector_map_select_pkg::BIT_SWAP] ? vector_map_select_pkg::MAP_RAM_ZERO : vector_map_select_pkg::MAP_RAM_ONE)
                 : (s.exp_en ? vector_map_select_pkg::MAP_EXPANSION : vector_map_select_pkg::MAP_BOOT_ROM);
  assign map_base = (cur_map == vector_map_select_pkg::MAP_BOOT_ROM) ? vector_map_select_pkg::BOOT_ROM_VEC_BASE
                                                         : vector_map_select_pkg::RAM_VEC_BASE;
  assign active_map_out = cur_map;
  assign compat_mode_out = vector_map_select_pkg::compat_mode_t'({s.status_one[vector_map_select_pkg::BIT_OBJ_COMPAT],
                                                     s.status_one[vector_map_select_pkg::BIT_ADDR_COMPAT]});
  assign ram_block_zero_free_out = cur_map != vector_map_select_pkg::MAP_RAM_ZERO;
  assign ram_block_one_free_out = cur_map != vector_map_select_pkg::MAP_RAM_ONE;
  assign expansion_vector_enable_out = s.exp_en;
  assign vector_out = s.rsp;
  assign cpu_int_out = s.cpu_int;
  assign group_ack_out = s.ack;
  assign interrupt_out = |(s.irq_status & s.irq_enable);

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.cpu_int = 12'h000;
    next_s.rsp.valid = 1'b0;
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    wr_err = 1'b0;
    tmp = 32'h00000000;
    // read decode, no side effects
    if (rd.addr == vector_map_select_pkg::OFF_STATUS_ONE) begin
      rd_data = {16'h0000, s.status_one};
    end else if (rd.addr == vector_map_select_pkg::OFF_STATUS_SETCLR || rd.addr == vector_map_select_pkg::OFF_IRQ_CLEAR) begin
      rd_data = 32'h00000000;
    end else if (rd.addr == vector_map_select_pkg::OFF_ALLOW) begin
      rd_data = {31'h00000000, s.allow};
    end else if (rd.addr == vector_map_select_pkg::OFF_ACK) begin
      rd_data = {20'h00000, s.ack};
    end else if (rd.addr == vector_map_select_pkg::OFF_IRQ_STATUS) begin
      rd_data = {30'h00000000, s.irq_status};
    end else if (rd.addr == vector_map_select_pkg::OFF_IRQ_ENABLE) begin
      rd_data = {30'h00000000, s.irq_enable};
    end else if (vector_map_select_pkg::in_window(rd.addr, vector_map_select_pkg::OFF_ENABLE_BASE, vector_map_select_pkg::NUM_GROUPS)) begin
      rd_data = {24'h000000, s.enable[vector_map_select_pkg::word_index(rd.addr, vector_map_select_pkg::OFF_ENABLE_BASE)]};
    end else if (vector_map_select_pkg::in_window(rd.addr, vector_map_select_pkg::OFF_FLAG_BASE, vector_map_select_pkg::NUM_GROUPS)) begin
      rd_data = {24'h000000, s.flag[vector_map_select_pkg::word_index(rd.addr, vector_map_select_pkg::OFF_FLAG_BASE)]};
    end else if (rd.addr == vector_map_select_pkg::OFF_EXP_CTRL) begin
      rd_data = {31'h00000000, s.exp_en};
    end else if (vector_map_select_pkg::in_window(rd.addr, vector_map_select_pkg::OFF_VECT_BASE, vector_map_select_pkg::NUM_VECT)) begin
      rd_data = s.vect[vector_map_select_pkg::word_index(rd.addr, vector_map_select_pkg::OFF_VECT_BASE)];
    end else begin
      rd_err = 1'b1;
    end
    // write decode; hardware events below are applied later so they win
    if (wr.valid) begin
      if (wr.addr == vector_map_select_pkg::OFF_STATUS_ONE) begin
        tmp = vector_map_select_pkg::merge_bytes({16'h0000, s.status_one}, wr.data, wr.strb);
        next_s.status_one = tmp[15:0];
      end else if (wr.addr == vector_map_select_pkg::OFF_STATUS_SETCLR) begin
        next_s.status_one = (s.status_one | wr.data[15:0]) & ~wr.data[31:16];
      end else if (wr.addr == vector_map_select_pkg::OFF_ALLOW) begin
        if (wr.strb[0]) next_s.allow = wr.data[vector_map_select_pkg::BIT_ALLOW];
      end else if (wr.addr == vector_map_select_pkg::OFF_ACK) begin
        tmp = vector_map_select_pkg::merge_bytes(32'h00000000, wr.data, wr.strb);
        next_s.ack = s.ack & ~tmp[11:0];
      end else if (wr.addr == vector_map_select_pkg::OFF_IRQ_STATUS) begin
        wr_err = 1'b0;
      end else if (wr.addr == vector_map_select_pkg::OFF_IRQ_CLEAR) begin
        tmp = vector_map_select_pkg::merge_bytes(32'h00000000, wr.data, wr.strb);
        next_s.irq_status = s.irq_status & ~tmp[1:0];
      end else if (wr.addr == vector_map_select_pkg::OFF_IRQ_ENABLE) begin
        tmp = vector_map_select_pkg::merge_bytes({30'h00000000, s.irq_enable}, wr.data, wr.strb);
        next_s.irq_enable = tmp[1:0];
      end else if (vector_map_select_pkg::in_window(wr.addr, vector_map_select_pkg::OFF_ENABLE_BASE, vector_map_select_pkg::NUM_GROUPS)) begin
        if (wr.strb[0]) next_s.enable[vector_map_select_pkg::word_index(wr.addr, vector_map_select_pkg::OFF_ENABLE_BASE)] = wr.data[7:0];
      end else if (vector_map_select_pkg::in_window(wr.addr, vector_map_select_pkg::OFF_FLAG_BASE, vector_map_select_pkg::NUM_GROUPS)) begin
        // flags ignore writes so a racing request is never dropped
        wr_err = 1'b0;
      end else if (wr.addr == vector_map_select_pkg::OFF_EXP_CTRL) begin
        if (wr.strb[0]) next_s.exp_en = wr.data[vector_map_select_pkg::BIT_EXP_EN];
      end else if (vector_map_select_pkg::in_window(wr.addr, vector_map_select_pkg::OFF_VECT_BASE, vector_map_select_pkg::NUM_VECT)) begin
        if (s.allow) begin
          next_s.vect[vector_map_select_pkg::word_index(wr.addr, vector_map_select_pkg::OFF_VECT_BASE)] = vector_map_select_pkg::merge_bytes(
            s.vect[vector_map_select_pkg::word_index(wr.addr, vector_map_select_pkg::OFF_VECT_BASE)], wr.data, wr.strb);
        end else begin
          next_s.irq_status[vector_map_select_pkg::EV_BLOCKED] = 1'b1;
        end
      end else begin
        wr_err = 1'b1;
      end
    end
    // forwarding; the set overrides a software clear of the same cycle
    for (int g = 0; g < vector_map_select_pkg::NUM_GROUPS; g++) begin
      if (|(s.flag[g] & s.enable[g]) && !s.ack[g]) begin
        next_s.cpu_int[g] = 1'b1;
        next_s.ack[g] = 1'b1;
      end
    end
    // vector fetch
    if (fetch_in.valid) begin
      next_s.rsp.valid = 1'b1;
      next_s.rsp.fallback = 1'b0;
      next_s.rsp.data = 32'h00000000;
      if (fetch_in.reset_vec) begin
        next_s.rsp.map = vector_map_select_pkg::MAP_BOOT_ROM;
        next_s.rsp.addr = vector_map_select_pkg::BOOT_ROM_VEC_BASE;
      end else begin
        next_s.rsp.map = cur_map;
        if (cur_map == vector_map_select_pkg::MAP_EXPANSION) begin
          next_s.rsp.addr = vector_map_select_pkg::vec_addr(vector_map_select_pkg::EXP_VEC_BASE,
                                               vector_map_select_pkg::GROUP_IDX_BASE + {1'b0, pick_slot});
          if (grp_ok) begin
            next_s.rsp.data = s.vect[pick_slot];
            next_s.rsp.fallback = !found;
            // servicing drops the write allow, as the core does on entry
            next_s.allow = 1'b0;
            if (found) begin
              next_s.flag[grp][pick_idx] = 1'b0;
            end else begin
              next_s.irq_status[vector_map_select_pkg::EV_FALLBACK] = 1'b1;
            end
          end
        end else begin
          next_s.rsp.addr = vector_map_select_pkg::vec_addr(map_base, vector_map_select_pkg::CORE_IDX_BASE + {4'h0, grp});
        end
      end
    end
    // new requests after the service clear so an arrival is kept
    for (int g = 0; g < vector_map_select_pkg::NUM_GROUPS; g++) begin
      next_s.flag[g] = next_s.flag[g] | periph_req_in[g*8 +: 8];
    end
    if (!reset_n_in) begin
      next_s = '0;
      next_s.status_one = vector_map_select_pkg::STATUS_ONE_RESET;
    end
  end

  always_ff @(posedge mclk_in) begin
    s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helper logic read only by assertions
  logic [11:0] has_pend;
  logic [11:0] ready_grp;
  logic [95:0] flag_flat;
  logic fetch_v;
  logic wr_bit0;
  logic map_sel_bit;
  logic swap_bit;
  logic [31:0] first_vec;
  always_comb begin
    for (int g = 0; g < vector_map_select_pkg::NUM_GROUPS; g++) begin
      has_pend[g] = |(s.flag[g] & s.enable[g]);
      ready_grp[g] = has_pend[g] && !s.ack[g];
    end
  end
  assign flag_flat = s.flag;
  assign fetch_v = fetch_in.valid && !fetch_in.reset_vec;
  assign wr_bit0 = wr.data[0];
  assign map_sel_bit = s.status_one[vector_map_select_pkg::BIT_MAP_SEL];
  assign swap_bit = s.status_one[vector_map_select_pkg::BIT_SWAP];
  assign first_vec = grp_ok ? s.vect[{grp, 3'h0}] : 32'h00000000;

  sequence exp_fetch_s;
    fetch_v && cur_map == vector_map_select_pkg::MAP_EXPANSION && grp_ok;
  endsequence
  sequence blocked_wr_s;
    wr.valid && vector_map_select_pkg::in_window(wr.addr, vector_map_select_pkg::OFF_VECT_BASE, vector_map_select_pkg::NUM_VECT) && !s.allow;
  endsequence

  AST_RESET_STATE: assert property (@(posedge mclk_in) !reset_n_in |=>
    active_map_out == vector_map_select_pkg::MAP_BOOT_ROM && !expansion_vector_enable_out
    && compat_mode_out == vector_map_select_pkg::MODE_OBJECT && swap_bit && map_sel_bit)
    else $error("reset state wrong");
  AST_RESET_VEC: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    fetch_in.valid && fetch_in.reset_vec |=> vector_out.valid
    && vector_out.map == vector_map_select_pkg::MAP_BOOT_ROM && vector_out.addr == vector_map_select_pkg::BOOT_ROM_VEC_BASE)
    else $error("reset vector not from boot rom");
  AST_MAP_HIGH: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    fetch_v && map_sel_bit |=> vector_out.map == ($past(s.exp_en) ? vector_map_select_pkg::MAP_EXPANSION
    : vector_map_select_pkg::MAP_BOOT_ROM) && (vector_out.addr[21:8] == vector_map_select_pkg::EXP_VEC_BASE[21:8]
    || vector_out.addr[21:6] == vector_map_select_pkg::BOOT_ROM_VEC_BASE[21:6]))
    else $error("map one fetch from wrong place");
  AST_MAP_LOW: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    fetch_v && !map_sel_bit |=> vector_out.addr[21:6] == 16'h0000 && vector_out.map ==
    ($past(swap_bit) ? vector_map_select_pkg::MAP_RAM_ZERO : vector_map_select_pkg::MAP_RAM_ONE))
    else $error("map zero fetch from wrong block");
  AST_RAM_FREE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    map_sel_bit |-> ram_block_zero_free_out && ram_block_one_free_out)
    else $error("ram block restricted outside ram maps");
  AST_COMPAT: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    wr.valid && wr.addr == vector_map_select_pkg::OFF_STATUS_ONE && wr.strb[1] && wr.data[9:8] == 2'b10
    |=> compat_mode_out == vector_map_select_pkg::MODE_NATIVE)
    else $error("compat mode decode wrong");
  AST_EXP_WR: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    wr.valid && wr.addr == vector_map_select_pkg::OFF_EXP_CTRL && wr.strb[0]
    |=> expansion_vector_enable_out == $past(wr_bit0))
    else $error("expansion enable write lost");
  AST_GATE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) |-> (cpu_int_out & ~$past(has_pend)) == 12'h000)
    else $error("request without flagged enabled source");
  AST_HOLD: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) |-> (cpu_int_out & $past(group_ack_out)) == 12'h000)
    else $error("acknowledged group reached cpu");
  AST_FORWARD: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ready_grp != 12'h000 |=> cpu_int_out == $past(ready_grp)
    && (group_ack_out & $past(ready_grp)) == $past(ready_grp))
    else $error("forward did not set acknowledge");
  AST_FLAG_CLEAR: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) && (|($past(flag_flat) & ~flag_flat)) |-> $past(fetch_v))
    else $error("flag cleared without fetch");
  AST_PICK: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    exp_fetch_s ##0 pend == 8'h00 |=> vector_out.valid && vector_out.fallback
    && vector_out.data == $past(first_vec))
    else $error("fallback vector wrong");
  AST_PROTECT: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    blocked_wr_s |=> $stable(s.vect) && s.irq_status[vector_map_select_pkg::EV_BLOCKED])
    else $error("protected vector write took effect");
endmodule

// File: cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // bench command and forwarded interrupts
  input wire logic go_in,
  input wire logic rv_in,
  input wire logic [3:0] grp_in,
  input wire logic [11:0] int_in,
  // fetch towards the device
  output vector_map_select_pkg::fetch_req_t fetch_out
);
  // never writes flags or enables, it only fetches
  always_ff @(posedge mclk_in) begin
    fetch_out <= '0;
    if (reset_n_in && go_in) begin
      fetch_out <= '{1'b1, rv_in, grp_in};
    end else if (reset_n_in && int_in != 12'h000) begin
      // lowest group wins, as the cpu fixes order across groups
      fetch_out.valid <= 1'b1;
      for (int i = 11; i >= 0; i--) begin
        if (int_in[i]) fetch_out.group <= 4'(i);
      end
    end
  end
endmodule

// File: interrupt_vector_map_select_bench.sv
`timescale 1ns/1ps
module interrupt_vector_map_select_bench;
  logic mclk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, go = 0, rv = 0;
  logic [31:0] aw = 0, wd = 0, ar = 0, rdat, d, v;
  logic [95:0] preq = 0;
  logic [3:0] grp = 0;
  logic [1:0] brs, rrs, resp, mp, cm;
  logic awr, wrd, bv, arr, rvl, irq, zf, of, ee;
  logic [11:0] ci;
  logic [11:0] ack;
  logic [31:0] vec [96];
  vector_map_select_pkg::fetch_req_t fr;
  vector_map_select_pkg::vector_rsp_t vo;
  int err_total = 0, n_checks = 0, cyc = 0, npls = 0, g, y, i;
  always #25 mclk = ~mclk;
  interrupt_vector_map_select dut (.mclk_in(mclk), .reset_n_in(rst_n), .s_axi_awaddr_in(aw),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(brs), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bre), .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rrs), .s_axi_rvalid_out(rvl), .s_axi_rready_in(rre),
    .periph_req_in(preq), .fetch_in(fr), .vector_out(vo), .cpu_int_out(ci), .group_ack_out(ack),
    .active_map_out(mp), .compat_mode_out(cm), .ram_block_zero_free_out(zf),
    .ram_block_one_free_out(of), .expansion_vector_enable_out(ee), .interrupt_out(irq));
  cpu_model cpu (.mclk_in(mclk), .reset_n_in(rst_n), .go_in(go), .rv_in(rv), .grp_in(grp),
    .int_in(ci), .fetch_out(fr));
  ////////////////////////////////
  task automatic end_sim;
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] a);
    n_checks++;
    if (a !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", s, e, a);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] x);
    @(posedge mclk);
    aw <= a; wd <= x; awv <= 1; wv <= 1; bre <= 1;
    forever begin
      @(posedge mclk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
      if (bv) break;
    end
    resp = brs; bre <= 0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge mclk);
    ar <= a; arv <= 1; rre <= 1;
    forever begin
      @(posedge mclk);
      if (arr) arv <= 0;
      if (rvl) break;
    end
    d = rdat; resp = rrs; rre <= 0;
  endtask
  task automatic fetch(input logic r, input logic [3:0] gg);
    @(posedge mclk); go <= 1; rv <= r; grp <= gg;
    @(posedge mclk); go <= 0;
    repeat (4) @(posedge mclk);
  endtask
  // one-cycle request, then room for forward and fetch
  task automatic pulse;
    @(posedge mclk); preq[i] <= 1;
    @(posedge mclk); preq[i] <= 0;
    repeat (6) @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (rst_n && ci != 12'h000) npls++;
    if (cyc == 20000) begin
      err_total++;
      end_sim;
    end
  end
  ////////////////////////////////
  initial begin
    void'($urandom(32'h0aa3));
    repeat (5) @(posedge mclk);
    rst_n <= 1;
    rd(0); chk("status_one", 32'h0808, d);
    rd(32'hCE0); chk("exp_ctrl", 0, d);
    rd(32'hFFC); chk("unmapped", 2, resp);
    wr(32'hFFC, 1); chk("wr_unmapped", 2, resp);
    g = $urandom_range(11); y = $urandom_range(7); i = 8 * g + y; v = $urandom;
    wr(32'h18, 3);
    wr(32'h1000 + 4 * i, v); chk("blocked_irq", 1, irq);
    chk("blocked_resp", 0, resp);
    wr(32'h14, 2); chk("irq_clear", 0, irq);
    wr(8, 1); wr(32'h1000 + 4 * i, v); vec[i] = v;
    rd(32'h1000 + 4 * i); chk("vector", vec[i], d);
    wr(32'hCE0, 1); chk("map", 2, mp);
    chk("exp_en", 1, ee);
    wr(32'h40 + 4 * g, 1 << y);
    pulse; chk("ack", 1, ack[g]);
    chk("v_addr", 22'hD00 + 2 * (32 + i), vo.addr);
    chk("v_data", vec[i], vo.data);
    rd(32'h80 + 4 * g); chk("flag_clr", 0, d);
    rd(8); chk("allow_clr", 0, d);
    // second request lands while the group is still acknowledged
    pulse; chk("held", 1, npls);
    rd(32'h80 + 4 * g); chk("flag_set", 1 << y, d);
    wr(32'hC, 1 << g); repeat (6) @(posedge mclk); chk("again", 2, npls);
    chk("v_data2", vec[i], vo.data);
    fetch(0, 4'(g)); chk("fallback", 1, vo.fallback);
    chk("fb_addr", 22'hD00 + 2 * (32 + 8 * g), vo.addr);
    chk("irq_fb", 1, irq);
    wr(32'h18, 0); chk("irq_mask", 0, irq);
    for (int k = 0; k < 4; k++) begin
      wr(0, (32'(k[1]) << 11) | (32'(k) << 8) | (32'(k[0]) << 3));
      chk("compat", k, cm);
      chk("map", k[0] ? 2 : (k[1] ? 1 : 0), mp);
      chk("free", k[0] ? 3 : (k[1] ? 1 : 2), {zf, of});
      fetch(1, 0); chk("rst_vec", 22'h3FFFC0, vo.addr);
      fetch(0, 4'(k));
      chk("vec_addr", k[0] ? 32'hD00 + 2 * (32 + 8 * k) : 2 + 2 * k, vo.addr);
    end
    @(posedge mclk) rst_n <= 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    rd(32'hCE0); chk("exp_rst", 0, d);
    chk("ee_rst", 0, ee);
    rd(0); chk("status_rst", 32'h0808, d);
    wr(4, 32'h08000000); rd(0); chk("setclr", 32'h0008, d);
    end_sim;
  end
endmodule
